/* File: hw/fcg_defs.vh */
// Shared constants of the frame checker copies and the frame generator.
// Assumes a 200 MHz diagnostic clock and the PHY management address map.
`ifndef FCG_DEFS_VH
`define FCG_DEFS_VH

// Management register addresses.
`define FCG_A_RXERR       16'h0014
`define FCG_A_ODD_PRE     16'h9412
`define FCG_A_DRIBBLE     16'h9413
`define FCG_A_FALSE_CAR   16'h9414
`define FCG_A_GEN_EN      16'h9415
`define FCG_A_CTRL        16'h9416
`define FCG_A_CONT        16'h9417
`define FCG_A_IRQ_EN      16'h9418
`define FCG_A_FRM_LEN     16'h941A
`define FCG_A_IFG         16'h941B
`define FCG_A_NFRM_H      16'h941C
`define FCG_A_NFRM_L      16'h941D
`define FCG_A_DONE        16'h941E

// Field positions and reset values.
`define FCG_RESTART_BIT   3
`define FCG_PAT_MSB       2
`define FCG_RST_PAT       3'h1
`define FCG_RST_NFRM_H    16'h0000
`define FCG_RST_NFRM_L    16'h0100
`define FCG_RST_FRM_LEN   16'h006B
`define FCG_RST_IFG       8'h0C

// Payload pattern codes.
`define FCG_PAT_STOP      3'h0
`define FCG_PAT_RAND      3'h1
`define FCG_PAT_ZERO      3'h2
`define FCG_PAT_ONES      3'h3
`define FCG_PAT_ALT55     3'h4
`define FCG_PAT_DECR      3'h5

// Frame layout in bytes.
`define FCG_PRE_BYTES     4'h8
`define FCG_HDR_LAST      16'h000D
`define FCG_FCS_LAST      16'h0003

// Byte times and the clock period in ns.
`define FCG_CLK_NS        5
`define FCG_BYTE_NS_100   80
`define FCG_BYTE_NS_10    800
`define FCG_BYTE_CYC_100  (`FCG_BYTE_NS_100 / `FCG_CLK_NS)
`define FCG_BYTE_CYC_10   (`FCG_BYTE_NS_10 / `FCG_CLK_NS)

`endif

/* File: hw/fcg_err_counter.v */
// One frame checker event counter with a latched readable copy.
// Assumes the event pulse comes from receive logic on the same clock.
module fcg_err_counter #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             countEvt,
    input  wire             latch,
    output reg  [WIDTH-1:0] latched
);
    reg [WIDTH-1:0] live;

    // The live count wraps; only the copy is visible to software.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live    <= {WIDTH{1'b0}};
            latched <= {WIDTH{1'b0}};
        end else begin
            if (countEvt) begin
                live <= live + {{(WIDTH-1){1'b0}}, 1'b1};
            end
            if (latch) begin
                latched <= live;
            end
        end
    end
endmodule // fcg_err_counter

/* File: hw/fcg_payload_src.v */
// Payload byte source of the frame generator.
// Assumes frameStart precedes the first payload byte of each frame.
`include "fcg_defs.vh"
module fcg_payload_src (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [2:0] pattern,
    input  wire       frameStart,
    input  wire       advance,
    output reg  [7:0] payloadByte
);
    reg [15:0] lfsr;
    reg [7:0]  decr;

    // A 16-bit maximal LFSR; its seed only needs to be non-zero.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr <= 16'hACE1;
            decr <= 8'hFF;
        end else begin
            if (frameStart) begin
                decr <= 8'hFF;
            end else if (advance) begin
                decr <= decr - 8'h01;
            end
            if (advance) begin
                lfsr <= {lfsr[14:0],
                         lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            end
        end
    end

    always @* begin
        case (pattern)
            `FCG_PAT_RAND:  payloadByte = lfsr[7:0];
            `FCG_PAT_ZERO:  payloadByte = 8'h00;
            `FCG_PAT_ONES:  payloadByte = 8'hFF;
            `FCG_PAT_ALT55: payloadByte = 8'h55;
            `FCG_PAT_DECR:  payloadByte = decr;
            default:        payloadByte = 8'h00;
        endcase
    end
endmodule // fcg_payload_src

/* File: hw/fcg_top.v */
// Frame checker latched copies and built-in frame generator of the PHY.
// Assumes management strobes and receive events on the diagnostic clock.
//
// Functional notes
// - Count odd preamble frames in 100 Mbit mode.
// - Receive error counter read snapshots all copies.
// - Count dribble frames in 10 Mbit mode.
// - Count entries into bad start delimiter state.
// - Copies are 16-bit read-only, reset zero.
// - Enabled generator replaces MAC transmit data.
// - Restart bit restarts generator and self-clears.
// - Pattern field selects payload byte source.
// - Pattern zero: finish frame, then stop.
// - Continuous mode ignores frame count forever.
// - Burst mode sends programmed frames then stops.
// - Interrupt enable raises event on burst end.
// - Event reported as status bit seven outside.
// - 32-bit frame count loads on enable/restart.
// - Done flag set on burst end, read-cleared.
// - Frame is data field plus 18 bytes.
`include "fcg_defs.vh"
module fcg_top #(
    parameter [47:0] SRC_ADDR = 48'h02_00_00_00_00_01,
    parameter [47:0] DST_ADDR = 48'hFF_FF_FF_FF_FF_FF
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        speed100,
    input  wire        diagClkEn,
    input  wire        oddPreambleEvt,
    input  wire        dribbleEvt,
    input  wire        falseCarrierEvt,
    input  wire        macTxEn,
    input  wire [7:0]  macTxData,
    input  wire [15:0] mgmtAddr,
    input  wire        mgmtWrite,
    input  wire        mgmtRead,
    input  wire [15:0] mgmtWdata,
    output reg  [15:0] mgmtRdata,
    output reg         mgmtRdValid,
    output reg         phyTxEn,
    output reg  [7:0]  phyTxData,
    output reg         fgIrqEvent
);
    localparam ST_IDLE = 3'h0;
    localparam ST_PRE  = 3'h1;
    localparam ST_HDR  = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_FCS  = 3'h4;
    localparam ST_GAP  = 3'h5;

    localparam integer CYC100 = `FCG_BYTE_CYC_100;
    localparam integer CYC10  = `FCG_BYTE_CYC_10;

    // Register select codes shared by read and write decoding.
    localparam [3:0] R_NONE  = 4'h0;
    localparam [3:0] R_ODD   = 4'h1;
    localparam [3:0] R_DRIB  = 4'h2;
    localparam [3:0] R_FCAR  = 4'h3;
    localparam [3:0] R_EN    = 4'h4;
    localparam [3:0] R_CTRL  = 4'h5;
    localparam [3:0] R_CONT  = 4'h6;
    localparam [3:0] R_IRQ   = 4'h7;
    localparam [3:0] R_LEN   = 4'h8;
    localparam [3:0] R_IFG   = 4'h9;
    localparam [3:0] R_NFH   = 4'hA;
    localparam [3:0] R_NFL   = 4'hB;
    localparam [3:0] R_DONE  = 4'hC;

    function [3:0] regSel;
        input [15:0] a;
        begin
            if (a == `FCG_A_ODD_PRE) regSel = R_ODD;
            else if (a == `FCG_A_DRIBBLE) regSel = R_DRIB;
            else if (a == `FCG_A_FALSE_CAR) regSel = R_FCAR;
            else if (a == `FCG_A_GEN_EN) regSel = R_EN;
            else if (a == `FCG_A_CTRL) regSel = R_CTRL;
            else if (a == `FCG_A_CONT) regSel = R_CONT;
            else if (a == `FCG_A_IRQ_EN) regSel = R_IRQ;
            else if (a == `FCG_A_FRM_LEN) regSel = R_LEN;
            else if (a == `FCG_A_IFG) regSel = R_IFG;
            else if (a == `FCG_A_NFRM_H) regSel = R_NFH;
            else if (a == `FCG_A_NFRM_L) regSel = R_NFL;
            else if (a == `FCG_A_DONE) regSel = R_DONE;
            else regSel = R_NONE;
        end
    endfunction

    // Reflected Ethernet CRC-32, one byte at a time.
    function [31:0] crcByte;
        input [31:0] c;
        input [7:0]  d;
        integer i;
        reg [31:0] r;
        begin
            r = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (r[0] ^ d[i]) r = (r >> 1) ^ 32'hEDB88320;
                else r = r >> 1;
            end
            crcByte = r;
        end
    endfunction

    wire [3:0] wrSel = mgmtWrite ? regSel(mgmtAddr) : R_NONE;
    wire [3:0] rdSel = mgmtRead ? regSel(mgmtAddr) : R_NONE;

    // Software registers.
    reg        generatorEnable;
    reg [2:0]  payloadPatternSelect;
    reg        continuousModeSelect;
    reg        generatorIrqEnable;
    reg [15:0] dataFieldLength;
    reg [7:0]  gapLength;
    reg [15:0] frameCountHigh;
    reg [15:0] frameCountLow;
    reg        burstDoneFlag;

    // Generator state.
    reg [2:0]  state;
    reg [15:0] idx;
    reg [31:0] framesLeft;
    reg        active;
    reg [31:0] crc;
    reg        genEn;
    reg [7:0]  genData;
    reg [7:0]  byteCnt;
    reg        byteTick;
    reg [7:0]  hdrByte;

    // Checker copies.
    wire        rxErrRead = mgmtRead && (mgmtAddr == `FCG_A_RXERR);
    wire [2:0]  evtVec;
    wire [47:0] copies;

    assign evtVec[0] = oddPreambleEvt & speed100;
    assign evtVec[1] = dribbleEvt & ~speed100;
    assign evtVec[2] = falseCarrierEvt;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gCopy
            fcg_err_counter #(
                .WIDTH (16)
            ) uCnt (
                .clk      (clk),
                .rst_n    (rst_n),
                .countEvt (evtVec[g]),
                .latch    (rxErrRead),
                .latched  (copies[16*g+15:16*g])
            );
        end
    endgenerate

    // A write that turns the enable on, or a restart, reloads the burst.
    wire enRise = (wrSel == R_EN) && mgmtWdata[0] && !generatorEnable;
    wire restartReq = (wrSel == R_CTRL) && mgmtWdata[`FCG_RESTART_BIT];
    wire loadBurst = enRise || restartReq;

    // The generator advances only on byte ticks while the clock is gated on.
    wire step = byteTick && diagClkEn && generatorEnable;
    wire frameStart = step && (state == ST_IDLE) && active &&
                      (payloadPatternSelect != `FCG_PAT_STOP) &&
                      (continuousModeSelect || (framesLeft != 32'h0));
    wire payAdvance = step && (state == ST_DATA);
    wire burstEnd = step && (state == ST_IDLE) && active &&
                    !continuousModeSelect && (framesLeft == 32'h0);
    wire [7:0] payloadByte;

    fcg_payload_src uPay (
        .clk         (clk),
        .rst_n       (rst_n),
        .pattern     (payloadPatternSelect),
        .frameStart  (frameStart),
        .advance     (payAdvance),
        .payloadByte (payloadByte)
    );

    // Byte-rate enable for the selected line speed.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byteCnt  <= 8'h00;
            byteTick <= 1'b0;
        end else if (byteCnt == 8'h00) begin
            byteCnt  <= (speed100 ? CYC100[7:0] : CYC10[7:0]) - 8'h01;
            byteTick <= 1'b1;
        end else begin
            byteCnt  <= byteCnt - 8'h01;
            byteTick <= 1'b0;
        end
    end

    // Register writes and the read-cleared done flag.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            generatorEnable      <= 1'b0;
            payloadPatternSelect <= `FCG_RST_PAT;
            continuousModeSelect <= 1'b0;
            generatorIrqEnable   <= 1'b0;
            dataFieldLength      <= `FCG_RST_FRM_LEN;
            gapLength            <= `FCG_RST_IFG;
            frameCountHigh       <= `FCG_RST_NFRM_H;
            frameCountLow        <= `FCG_RST_NFRM_L;
            burstDoneFlag        <= 1'b0;
        end else begin
            if (wrSel == R_EN) generatorEnable <= mgmtWdata[0];
            if (wrSel == R_CTRL) begin
                payloadPatternSelect <= mgmtWdata[`FCG_PAT_MSB:0];
            end
            if (wrSel == R_CONT) continuousModeSelect <= mgmtWdata[0];
            if (wrSel == R_IRQ) generatorIrqEnable <= mgmtWdata[0];
            if (wrSel == R_LEN) dataFieldLength <= mgmtWdata;
            if (wrSel == R_IFG) gapLength <= mgmtWdata[7:0];
            if (wrSel == R_NFH) frameCountHigh <= mgmtWdata;
            if (wrSel == R_NFL) frameCountLow <= mgmtWdata;
            // Completion in the same cycle as the clearing read wins.
            if (burstEnd) begin
                burstDoneFlag <= 1'b1;
            end else if (rdSel == R_DONE) begin
                burstDoneFlag <= 1'b0;
            end
        end
    end

    // Register reads answer one cycle after the strobe; others read zero.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mgmtRdata   <= 16'h0000;
            mgmtRdValid <= 1'b0;
        end else begin
            mgmtRdValid <= mgmtRead;
            if (rdSel == R_ODD) mgmtRdata <= copies[15:0];
            else if (rdSel == R_DRIB) mgmtRdata <= copies[31:16];
            else if (rdSel == R_FCAR) mgmtRdata <= copies[47:32];
            else if (rdSel == R_EN) mgmtRdata <= {15'h0000, generatorEnable};
            // Restart always reads back as zero since it clears itself.
            else if (rdSel == R_CTRL) begin
                mgmtRdata <= {13'h0000, payloadPatternSelect};
            end
            else if (rdSel == R_CONT) begin
                mgmtRdata <= {15'h0000, continuousModeSelect};
            end
            else if (rdSel == R_IRQ) begin
                mgmtRdata <= {15'h0000, generatorIrqEnable};
            end
            else if (rdSel == R_LEN) mgmtRdata <= dataFieldLength;
            else if (rdSel == R_IFG) mgmtRdata <= {8'h00, gapLength};
            else if (rdSel == R_NFH) mgmtRdata <= frameCountHigh;
            else if (rdSel == R_NFL) mgmtRdata <= frameCountLow;
            else if (rdSel == R_DONE) mgmtRdata <= {15'h0000, burstDoneFlag};
            else mgmtRdata <= 16'h0000;
        end
    end

    // Frame generator sequence.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            idx        <= 16'h0000;
            framesLeft <= 32'h0000_0000;
            active     <= 1'b0;
            crc        <= 32'hFFFF_FFFF;
            genEn      <= 1'b0;
            genData    <= 8'h00;
        end else if (!generatorEnable || loadBurst) begin
            // Disabling aborts at once; restart begins a fresh burst.
            state  <= ST_IDLE;
            idx    <= 16'h0000;
            genEn  <= 1'b0;
            active <= loadBurst;
            if (loadBurst) begin
                framesLeft <= {frameCountHigh, frameCountLow};
            end
        end else if (step) begin
            case (state)
                ST_IDLE: begin
                    genEn <= 1'b0;
                    if (burstEnd) begin
                        active <= 1'b0;
                    end else if (frameStart) begin
                        state   <= ST_PRE;
                        idx     <= 16'h0001;
                        genEn   <= 1'b1;
                        genData <= 8'h55;
                    end
                end
                ST_PRE: begin
                    if (idx == {12'h000, `FCG_PRE_BYTES - 4'h1}) begin
                        genData <= 8'hD5;
                        state   <= ST_HDR;
                        idx     <= 16'h0000;
                        crc     <= 32'hFFFF_FFFF;
                    end else begin
                        genData <= 8'h55;
                        idx     <= idx + 16'h0001;
                    end
                end
                ST_HDR: begin
                    // Addresses and length field: 14 of the 18 extra bytes.
                    genData <= hdrByte;
                    crc     <= crcByte(crc, hdrByte);
                    if (idx == `FCG_HDR_LAST) begin
                        idx   <= 16'h0000;
                        state <= (dataFieldLength == 16'h0000) ?
                                 ST_FCS : ST_DATA;
                    end else begin
                        idx <= idx + 16'h0001;
                    end
                end
                ST_DATA: begin
                    genData <= payloadByte;
                    crc     <= crcByte(crc, payloadByte);
                    if (idx == dataFieldLength - 16'h0001) begin
                        idx   <= 16'h0000;
                        state <= ST_FCS;
                    end else begin
                        idx <= idx + 16'h0001;
                    end
                end
                ST_FCS: begin
                    genData <= ~crc[8*idx[1:0] +: 8];
                    if (idx == `FCG_FCS_LAST) begin
                        idx   <= 16'h0000;
                        state <= ST_GAP;
                        if (!continuousModeSelect) begin
                            framesLeft <= framesLeft - 32'h1;
                        end
                    end else begin
                        idx <= idx + 16'h0001;
                    end
                end
                ST_GAP: begin
                    genEn <= 1'b0;
                    if (idx + 16'h0001 >= {8'h00, gapLength}) begin
                        // Back to idle; continuous mode never ends a burst.
                        state <= ST_IDLE;
                        idx   <= 16'h0000;
                    end else begin
                        idx <= idx + 16'h0001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    genEn <= 1'b0;
                end
            endcase
        end
    end

    // Header byte for the current index: destination, source, length.
    always @* begin
        if (idx < 16'h0006) begin
            hdrByte = DST_ADDR[8*(5-idx[2:0]) +: 8];
        end else if (idx < 16'h000C) begin
            hdrByte = SRC_ADDR[8*(11-idx[3:0]) +: 8];
        end else if (idx == 16'h000C) begin
            hdrByte = dataFieldLength[15:8];
        end else begin
            hdrByte = dataFieldLength[7:0];
        end
    end

    // Transmit source select and the completion event.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phyTxEn    <= 1'b0;
            phyTxData  <= 8'h00;
            fgIrqEvent <= 1'b0;
        end else begin
            if (generatorEnable) begin
                phyTxEn   <= genEn;
                phyTxData <= genData;
            end else begin
                phyTxEn   <= macTxEn;
                phyTxData <= macTxData;
            end
            // The status bit and its mask live in the interrupt block.
            fgIrqEvent <= burstEnd && generatorIrqEnable;
        end
    end
endmodule // fcg_top

/* File: sim/pfgac_props.sv */
// Checker of the frame checker copies and generator at the top ports.
// Assumes the management strobes and the line output share clk.
module pfgac_props (
    input wire logic        clk, rst_n, speed100, diagClkEn,
    input wire logic        oddPreambleEvt, dribbleEvt, falseCarrierEvt,
    input wire logic        macTxEn, mgmtWrite, mgmtRead,
    input wire logic [7:0]  macTxData, phyTxData,
    input wire logic [15:0] mgmtAddr, mgmtWdata, mgmtRdata,
    input wire logic        mgmtRdValid, phyTxEn, fgIrqEvent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic genOn;
    logic irqOn;
    logic doneExp;
    // Mirrors of the enable bits and of the sticky done flag.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            genOn <= 1'b0;
            irqOn <= 1'b0;
            doneExp <= 1'b0;
        end else begin
            if (mgmtWrite && mgmtAddr == 16'h9415) genOn <= mgmtWdata[0];
            if (mgmtWrite && mgmtAddr == 16'h9418) irqOn <= mgmtWdata[0];
            if (fgIrqEvent) doneExp <= 1'b1;
            else if (mgmtRead && mgmtAddr == 16'h941E) doneExp <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rd_answer; mgmtRead |=> mgmtRdValid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read unanswered");
    property p_rd_only; mgmtRdValid |-> $past(mgmtRead); endproperty
    a_rd_only: assert property (p_rd_only)
        else $error("stray read answer");
    property p_rxerr;
        mgmtRead && mgmtAddr == 16'h0014 |=> mgmtRdata == 16'h0000;
    endproperty
    a_rxerr: assert property (p_rxerr)
        else $error("snapshot read not zero");
    property p_restart;
        mgmtRead && mgmtAddr == 16'h9416 |=> mgmtRdata[15:3] == 13'h0000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart reads nonzero");
    property p_en_read;
        mgmtRead && mgmtAddr == 16'h9415
            |=> mgmtRdata == {15'h0000, $past(genOn)};
    endproperty
    a_en_read: assert property (p_en_read)
        else $error("enable readback wrong");
    property p_irq_gate; fgIrqEvent |-> irqOn ##1 !fgIrqEvent; endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("bad burst end pulse");
    property p_pass;
        !genOn && !$past(genOn) && !$past(genOn, 2)
            |-> phyTxEn == $past(macTxEn)
            && (!phyTxEn || phyTxData == $past(macTxData));
    endproperty
    a_pass: assert property (p_pass)
        else $error("MAC path not followed");
    property p_done;
        mgmtRead && mgmtAddr == 16'h941E && doneExp |=> mgmtRdata == 16'h0001;
    endproperty
    a_done: assert property (p_done)
        else $error("done flag lost");
    property p_quiet; fgIrqEvent |-> !phyTxEn; endproperty
    a_quiet: assert property (p_quiet)
        else $error("done while sending");
endmodule // pfgac_props

bind fcg_top pfgac_props u_props (.clk, .rst_n, .speed100, .diagClkEn,
    .oddPreambleEvt, .dribbleEvt, .falseCarrierEvt, .macTxEn, .mgmtWrite,
    .mgmtRead, .macTxData, .phyTxData, .mgmtAddr, .mgmtWdata, .mgmtRdata,
    .mgmtRdValid, .phyTxEn, .fgIrqEvent);

/* File: sim/pfgac_line_mon.sv */
// Line-side receiver model that measures the frames the block sends.
// Assumes each byte is held for BYTE_CYC clocks while phyTxEn is high.
module pfgac_line_mon #(
    parameter int BYTE_CYC = 16
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       phyTxEn,
    input  wire logic [7:0] phyTxData,
    output int              frames,
    output int              lastLen,
    output logic [7:0]      sfd,
    output logic [7:0]      firstData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev;
    int   cyc;
    // Bytes are sampled mid-way so a byte edge never decides the value.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frames <= 0;
            lastLen <= 0;
            cyc <= 0;
            prev <= 1'b0;
            sfd <= 8'h00;
            firstData <= 8'h00;
        end else begin
            prev <= phyTxEn;
            if (phyTxEn) begin
                cyc <= cyc + 1;
                if (!prev) frames <= frames + 1;
                if (cyc == 7 * BYTE_CYC + BYTE_CYC / 2) sfd <= phyTxData;
                if (cyc == 22*BYTE_CYC + BYTE_CYC/2) firstData <= phyTxData;
            end else begin
                cyc <= 0;
                if (prev) lastLen <= cyc / BYTE_CYC;
            end
        end
    end
endmodule // pfgac_line_mon

/* File: sim/phy_frame_gen_and_checker_tb.sv */
// Self-checking bench of the checker copies and the frame generator.
// Assumes the strobe register port and a 100 Mbit byte of 16 clocks.
module phy_frame_gen_and_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, speed100 = 1'b1, diagClkEn = 1'b0;
    logic        oddPreambleEvt = 1'b0, dribbleEvt = 1'b0;
    logic        falseCarrierEvt = 1'b0, macTxEn = 1'b0;
    logic        mgmtWrite = 1'b0, mgmtRead = 1'b0;
    logic [7:0]  macTxData = 8'h00;
    logic [15:0] mgmtAddr = 16'h0000, mgmtWdata = 16'h0000, mgmtRdata;
    logic        mgmtRdValid, phyTxEn, fgIrqEvent;
    logic [7:0]  phyTxData, sfd, firstData;
    int          n_mismatch = 0, n_compared = 0, frames, lastLen, f0, i;
    logic [15:0] addrs [12] = '{16'h9412, 16'h9413, 16'h9414, 16'h9415,
        16'h9416, 16'h9417, 16'h9418, 16'h941A, 16'h941B, 16'h941C,
        16'h941D, 16'h9419};
    logic [15:0] rstv [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0001, 16'h0000, 16'h0000, 16'h006B, 16'h000C, 16'h0000,
        16'h0100, 16'h0000};
    logic [7:0]  pexp [6] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h55, 8'hFF};

    fcg_top u_dut (.clk, .rst_n, .speed100, .diagClkEn, .oddPreambleEvt,
        .dribbleEvt, .falseCarrierEvt, .macTxEn, .macTxData, .mgmtAddr,
        .mgmtWrite, .mgmtRead, .mgmtWdata, .mgmtRdata, .mgmtRdValid,
        .phyTxEn, .phyTxData, .fgIrqEvent);
    pfgac_line_mon u_mon (.clk, .rst_n, .phyTxEn, .phyTxData, .frames,
        .lastLen, .sfd, .firstData);

    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge clk);
        mgmtAddr <= a;
        mgmtWdata <= d;
        mgmtWrite <= 1'b1;
        @(posedge clk);
        mgmtWrite <= 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] exp);
        @(posedge clk);
        mgmtAddr <= a;
        mgmtRead <= 1'b1;
        @(posedge clk);
        mgmtRead <= 1'b0;
        #1;
        check($sformatf("reg %h", a), exp,
            (mgmtRdValid === 1'b1) ? mgmtRdata : 16'hXXXX);
    endtask
    // Bits of m select odd preamble, dribble and false carrier pulses.
    task automatic evt(logic [2:0] m, int n);
        repeat (n) begin
            @(posedge clk);
            {oddPreambleEvt, dribbleEvt, falseCarrierEvt} <= m;
            @(posedge clk);
            {oddPreambleEvt, dribbleEvt, falseCarrierEvt} <= 3'b000;
        end
    endtask
    task automatic waitIrq(int lim);
        repeat (lim) begin
            @(posedge clk);
            #1;
            if (fgIrqEvent === 1'b1) break;
        end
        check("burst end", 16'h0001, fgIrqEvent);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #150us;
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 12; i++) rd(addrs[i], rstv[i]);
        $display("test reset values done");
        evt(3'b100, 3);
        evt(3'b010, 2);
        evt(3'b001, 1);
        rd(16'h9412, 16'h0000);
        rd(16'h0014, 16'h0000);
        rd(16'h9412, 16'h0003);
        rd(16'h9413, 16'h0000);
        rd(16'h9414, 16'h0001);
        wr(16'h9412, 16'hFFFF);
        rd(16'h9412, 16'h0003);
        @(posedge clk);
        speed100 <= 1'b0;
        evt(3'b010, 2);
        evt(3'b101, 1);
        rd(16'h0014, 16'h0000);
        rd(16'h9413, 16'h0002);
        rd(16'h9412, 16'h0003);
        rd(16'h9414, 16'h0002);
        $display("test checker copies done");
        @(posedge clk);
        macTxEn <= 1'b1;
        macTxData <= 8'hA5;
        speed100 <= 1'b1;
        diagClkEn <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check("mac pass", 16'h01A5, {7'h00, phyTxEn, phyTxData});
        wr(16'h941A, 16'h0001);
        wr(16'h941B, 16'h0001);
        wr(16'h941D, 16'h0002);
        wr(16'h9416, 16'h0003);
        wr(16'h9418, 16'h0001);
        f0 = frames;
        wr(16'h9415, 16'h0001);
        waitIrq(4000);
        check("burst frames", 16'd2, 16'(frames - f0));
        check("frame bytes", 16'd27, 16'(lastLen));
        check("delimiter", 16'h00D5, sfd);
        check("gen payload", 16'h00FF, firstData);
        rd(16'h941E, 16'h0001);
        rd(16'h941E, 16'h0000);
        $display("test burst done");
        for (i = 1; i < 6; i++) begin
            wr(16'h941D, 16'h0001);
            wr(16'h9416, 16'h0008 | i[15:0]);
            waitIrq(2000);
            if (i != 1) check("pattern", pexp[i], firstData);
            rd(16'h9416, i[15:0]);
        end
        $display("test patterns done");
        wr(16'h9417, 16'h0001);
        f0 = frames;
        wr(16'h9416, 16'h000B);
        repeat (2500) @(posedge clk);
        check("continuous", 16'h0001, frames - f0 >= 4);
        wr(16'h9416, 16'h0000);
        f0 = frames;
        repeat (1500) @(posedge clk);
        #1;
        check("stop count", 16'h0001, frames - f0 <= 1);
        check("stop whole", 16'd27, 16'(lastLen));
        check("stop idle", 16'h0000, phyTxEn);
        wr(16'h9415, 16'h0000);
        repeat (4) @(posedge clk);
        #1;
        check("mac again", 16'h01A5, {7'h00, phyTxEn, phyTxData});
        $display("test continuous and stop done");
        conclude();
    end
endmodule // phy_frame_gen_and_checker_tb
